// ==== include/uart_flags_pkg.sv ====
// constants and types shared by the uart control and status flag logic
package uart_flags_pkg;
  // register word offsets (byte addresses)
  localparam logic [11:0] serial_control_off = 12'h000;
  localparam logic [11:0] serial_data_off    = 12'h004;
  localparam logic [11:0] irq_status_off     = 12'h008;
  localparam logic [11:0] irq_enable_off     = 12'h00c;
  localparam logic [11:0] irq_clear_off      = 12'h010;
  localparam logic [11:0] fifo_status_off    = 12'h014;
  // serial control field positions
  localparam int frame_size_pos   = 7;
  localparam int reserved_pos     = 6;
  localparam int mp_filter_pos    = 5;
  localparam int rx_enable_pos    = 4;
  localparam int ninth_tx_pos     = 3;
  localparam int ninth_rx_pos     = 2;
  localparam int tx_done_pos      = 1;
  localparam int rx_avail_pos     = 0;
  // interrupt status bits
  localparam int irq_tx_pos       = 0;
  localparam int irq_rx_pos       = 1;
  localparam int irq_bits         = 2;
  // reset values
  localparam logic [7:0] control_reset = 8'h40;
  localparam logic [1:0] irq_en_reset  = 2'h0;
  // fifo defaults
  localparam int rx_depth_default = 4;
  localparam int tx_depth_default = 4;
  // frame size encodings
  typedef enum logic {frame_8bit, frame_9bit} frame_size_t;
endpackage

// ==== include/fifo_if.sv ====
// push and pop signals between the flag logic and its byte fifo
`timescale 1ns/1ns
interface fifo_if #(parameter int width = 9);
  logic             push;
  logic [width-1:0] wdata;
  logic             overwrite;
  logic             pop;
  logic [width-1:0] rdata;
  logic             empty;
  logic             full;
  modport owner (output push, wdata, overwrite, pop, input rdata, empty, full);
  modport store (input push, wdata, overwrite, pop, output rdata, empty, full);
endinterface

// ==== core/byte_fifo.sv ====
// small synchronous fifo with head output and overwrite of newest entry
`timescale 1ns/1ns
module byte_fifo #(
  parameter int width = 9,
  parameter int depth = 4
) (
  input  wire logic clk,
  input  wire logic rstn,
  fifo_if.store     port
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0]    rd_reg;
  logic [aw-1:0]    wr_reg;
  logic [aw:0]      count_reg;
  logic             do_push;
  logic             do_pop;
  logic             do_over;

  // overwrite only replaces the newest entry when full
  assign do_pop  = port.pop && count_reg != '0;
  assign do_push = port.push && (count_reg != (aw+1)'(depth) || do_pop); // pop frees a slot
  assign do_over = port.push && port.overwrite && !do_push;
  assign port.empty = count_reg == '0;
  assign port.full  = count_reg == (aw+1)'(depth);
  assign port.rdata = mem[rd_reg];

  // storage writes
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_reg] <= port.wdata;
    else if (do_over)
      mem[(wr_reg == '0) ? aw'(depth - 1) : wr_reg - aw'(1)] <= port.wdata;
  end

  // pointers wrap at depth
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_reg    <= '0;
      wr_reg    <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_push)
        wr_reg <= (wr_reg == aw'(depth - 1)) ? '0 : wr_reg + aw'(1);
      if (do_pop)
        rd_reg <= (rd_reg == aw'(depth - 1)) ? '0 : rd_reg + aw'(1);
      count_reg <= count_reg + (aw+1)'(do_push) - (aw+1)'(do_pop);
    end
  end
endmodule

// ==== core/uart_flags.sv ====
// uart control and status flags with apb register access
// Function
// - mode bit selects 8 or 9 bit frames
// - 8-bit filter: accept only stop bit one
// - 9-bit filter: accept only ninth bit one
// - receive enable gates fifo writes, resets zero
// - fifo stays readable while reception disabled
// - ninth tx bit sent only in 9-bit
// - tx done set at stop bit start
// - enabled tx done raises interrupt
// - rx available set at stop sample
// - rx available follows fifo non-empty
// - empty read returns last byte again
// - transmit starts when tx fifo nonempty
`timescale 1ns/1ns
module uart_flags
  import uart_flags_pkg::*;
#(
  parameter int rx_depth = rx_depth_default,
  parameter int tx_depth = tx_depth_default
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive frame engine side
  input  wire logic        rx_frame_valid,
  input  wire logic [7:0]  rx_frame_data,
  input  wire logic        rx_frame_bit9,
  input  wire logic        rx_frame_stop,
  // transmit frame engine side
  output logic             tx_start,
  output logic      [7:0]  tx_frame_data,
  output logic             tx_frame_bit9,
  output logic             tx_frame_9bit,
  input  wire logic        tx_frame_taken,
  input  wire logic        tx_stop_begin,
  // interrupt
  output logic             irq
);
  logic             frame_size_select;
  logic             multiproc_filter_enable;
  logic             rx_enable;
  logic             ninth_tx_bit;
  logic             ninth_rx_bit;
  logic             tx_done_flag;
  logic             rx_available_flag;
  logic [7:0]       last_rx_reg;
  logic [irq_bits-1:0] irq_status_reg;
  logic [irq_bits-1:0] irq_en_reg;
  logic             wr_en;
  logic             rd_en;
  logic             byte0_wr;
  logic             rx_accept;
  logic             rx_pop;
  logic [7:0]       control_view;
  logic [irq_bits-1:0] irq_set;

  fifo_if #(.width(9)) rxf ();
  fifo_if #(.width(9)) txf ();

  byte_fifo #(.width(9), .depth(rx_depth)) rx_store (
    .clk  (clk),
    .rstn (rstn),
    .port (rxf.store)
  );
  byte_fifo #(.width(9), .depth(tx_depth)) tx_store (
    .clk  (clk),
    .rstn (rstn),
    .port (txf.store)
  );

  // zero wait state slave; every access ends in its first access cycle
  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && penable && !pwrite;
  assign byte0_wr = wr_en && pstrb[0];
  assign pslverr  = psel && penable &&
                    !(paddr == serial_control_off || paddr == serial_data_off ||
                      paddr == irq_status_off || paddr == irq_enable_off ||
                      paddr == irq_clear_off || paddr == fifo_status_off);

  // filter in the selected frame size, then gate with receive enable
  always_comb
  begin
    if (!multiproc_filter_enable)
      rx_accept = 1'b1;
    else if (frame_size_select == frame_8bit)
      rx_accept = rx_frame_stop;
    else
      rx_accept = rx_frame_bit9;
    rx_accept = rx_accept && rx_enable && rx_frame_valid;
  end

  // ninth received bit holds stop bit in 8-bit mode
  assign rxf.push      = rx_accept;
  assign rxf.overwrite = 1'b0; // full receive fifo drops the byte
  assign rxf.wdata     = {(frame_size_select == frame_8bit) ? rx_frame_stop : rx_frame_bit9,
                          rx_frame_data};
  // pop allowed regardless of receive enable
  assign rx_pop        = rd_en && paddr == serial_data_off && !rxf.empty;
  assign rxf.pop       = rx_pop;

  // flag tracks fifo content; set lands with the push at stop sampling
  assign rx_available_flag = !rxf.empty;

  // transmit side: writes with pstrb[0] set queue, newest overwritten when full
  assign txf.push      = byte0_wr && paddr == serial_data_off;
  assign txf.overwrite = 1'b1;
  assign txf.wdata     = {ninth_tx_bit, pwdata[7:0]};
  assign txf.pop       = tx_frame_taken && !txf.empty;
  assign tx_start      = !txf.empty;
  assign tx_frame_data = txf.rdata[7:0];
  assign tx_frame_bit9 = txf.rdata[8] && frame_size_select == frame_9bit;
  assign tx_frame_9bit = frame_size_select;

  // control fields written by software
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_size_select       <= control_reset[frame_size_pos];
      multiproc_filter_enable <= control_reset[mp_filter_pos];
      rx_enable               <= control_reset[rx_enable_pos];
      ninth_tx_bit            <= control_reset[ninth_tx_pos];
    end
    else if (byte0_wr && paddr == serial_control_off)
    begin
      frame_size_select       <= pwdata[frame_size_pos];
      multiproc_filter_enable <= pwdata[mp_filter_pos];
      rx_enable               <= pwdata[rx_enable_pos];
      ninth_tx_bit            <= pwdata[ninth_tx_pos];
    end
  end

  // tx done: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tx_done_flag <= control_reset[tx_done_pos];
    else if (tx_stop_begin)
      tx_done_flag <= 1'b1;
    else if (byte0_wr && paddr == serial_control_off && !pwdata[tx_done_pos])
      tx_done_flag <= 1'b0;
  end

  // ninth rx bit and last byte follow the fifo head as it is read
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ninth_rx_bit <= 1'b0;
      last_rx_reg  <= 8'h00;
    end
    else if (rx_pop)
    begin
      ninth_rx_bit <= rxf.rdata[8];
      last_rx_reg  <= rxf.rdata[7:0];
    end
  end

  // sticky interrupt status; set beats clear
  assign irq_set[irq_tx_pos] = tx_stop_begin;
  assign irq_set[irq_rx_pos] = rx_accept && (!rxf.full || rx_pop);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_status_reg <= '0;
    else if (byte0_wr && paddr == irq_clear_off)
      irq_status_reg <= (irq_status_reg & ~pwdata[irq_bits-1:0]) | irq_set;
    else
      irq_status_reg <= irq_status_reg | irq_set;
  end

  // interrupt enables
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_en_reg <= irq_en_reset;
    else if (byte0_wr && paddr == irq_enable_off)
      irq_en_reg <= pwdata[irq_bits-1:0];
  end

  // level output; also held by live flags so an unserviced flag stays visible
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irq_status_reg & irq_en_reg) ||
             (irq_en_reg[irq_tx_pos] && tx_done_flag) ||
             (irq_en_reg[irq_rx_pos] && rx_available_flag);
  end

  assign control_view = {frame_size_select, control_reset[reserved_pos],
                         multiproc_filter_enable, rx_enable, ninth_tx_bit,
                         ninth_rx_bit, tx_done_flag, rx_available_flag};

  // read mux; a read of empty data returns the last byte
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
      unique case (paddr)
        serial_control_off: prdata = {24'h00_0000, control_view};
        serial_data_off:    prdata = {24'h00_0000,
                                      rxf.empty ? last_rx_reg : rxf.rdata[7:0]};
        irq_status_off:     prdata = {30'h0000_0000, irq_status_reg};
        irq_enable_off:     prdata = {30'h0000_0000, irq_en_reg};
        fifo_status_off:    prdata = {28'h000_0000, txf.full, txf.empty,
                                      rxf.full, rxf.empty};
        default:            prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== test/uart_flags_properties.sv ====
// port-level assertions for the uart flag block
`timescale 1ns/1ns
module uart_flags_properties
  import uart_flags_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_start,
  input wire logic        tx_frame_bit9,
  input wire logic        tx_frame_9bit,
  input wire logic        tx_stop_begin,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic       acc;
  logic       wr;
  logic [1:0] en_sh;
  // access phase and accepted write
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  // shadow of the interrupt enable, the only way to know it from outside
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      en_sh <= 2'h0;
    else if (wr && paddr == irq_enable_off)
      en_sh <= pwdata[1:0];
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; acc && paddr == 12'h100 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_idle; !acc |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_rsv; acc && !pwrite && paddr == serial_control_off |-> prdata[reserved_pos];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bit not one");
  property p_start; wr && paddr == serial_data_off |=> tx_start; endproperty
  a_start: assert property (p_start) else $error("no start after data write");
  property p_bit9; !tx_frame_9bit |-> !tx_frame_bit9; endproperty
  a_bit9: assert property (p_bit9) else $error("ninth bit sent in 8-bit mode");
  property p_mode;
    wr && paddr == serial_control_off |=> tx_frame_9bit == $past(pwdata[frame_size_pos]);
  endproperty
  a_mode: assert property (p_mode) else $error("frame size not taken");
  property p_txirq; tx_stop_begin && en_sh[irq_tx_pos] |-> ##[1:2] irq; endproperty
  a_txirq: assert property (p_txirq) else $error("no irq after tx done");
  property p_irq_en; irq |-> en_sh != 2'h0 || $past(en_sh) != 2'h0; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq with no enable");
  c_tx: cover property (tx_stop_begin);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule
bind uart_flags uart_flags_properties chk (.*);

// ==== test/serial_peer_model.sv ====
// behavioural remote transceiver on the frame engine ports
`timescale 1ns/1ns
module serial_peer_model #(
  parameter int gap = 3
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_frame_data,
  input  wire logic       tx_frame_bit9,
  output logic            rx_frame_valid,
  output logic      [7:0] rx_frame_data,
  output logic            rx_frame_bit9,
  output logic            rx_frame_stop,
  output logic            tx_frame_taken,
  output logic            tx_stop_begin,
  output logic      [8:0] last_tx
);
  int cnt;
  initial
  begin
    rx_frame_valid = 1'b0;
    rx_frame_data = 8'h00;
    rx_frame_bit9 = 1'b0;
    rx_frame_stop = 1'b0;
  end
  // one frame; fields inverted afterwards so stale values never match
  task automatic send(input logic [7:0] d, input logic b9, input logic st);
    @(posedge clk);
    rx_frame_valid <= 1'b1;
    rx_frame_data <= d;
    rx_frame_bit9 <= b9;
    rx_frame_stop <= st;
    @(posedge clk);
    rx_frame_valid <= 1'b0;
    rx_frame_data <= ~d;
    rx_frame_bit9 <= ~b9;
    rx_frame_stop <= ~st;
  endtask
  // take the head byte, report the stop bit gap cycles later
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      cnt <= 0;
      tx_frame_taken <= 1'b0;
      tx_stop_begin <= 1'b0;
      last_tx <= 9'h000;
    end
    else
    begin
      tx_frame_taken <= 1'b0;
      tx_stop_begin <= (cnt == 1);
      if (cnt > 0)
        cnt <= cnt - 1;
      else if (tx_start)
      begin
        tx_frame_taken <= 1'b1;
        last_tx <= {tx_frame_bit9, tx_frame_data};
        cnt <= gap;
      end
    end
endmodule

// ==== test/uart_flags_tb.sv ====
// self-checking bench for the uart flag block
`timescale 1ns/1ns
module uart_flags_tb;
  import uart_flags_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h1;
  logic [31:0] prdata, r;
  logic        pready, pslverr, err, irq, tx_start, tx_frame_bit9, tx_frame_9bit;
  logic        rx_frame_valid, rx_frame_bit9, rx_frame_stop, tx_frame_taken, tx_stop_begin;
  logic [7:0]  rx_frame_data, tx_frame_data;
  logic [8:0]  last_tx;
  int          n_fail = 0;
  int          tests_run = 0;
  always #2 clk = ~clk;
  uart_flags DUT (.*);
  serial_peer_model #(.gap(3)) peer (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer; answer taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    @(posedge clk);
    while (pready !== 1'b1 && i < 20)
    begin
      @(posedge clk);
      i++;
    end
    if (i == 20)
    begin
      n_fail++;
      complete_run;
    end
    else
    begin
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wait_stop;
    int i;
    i = 0;
    while (tx_stop_begin !== 1'b1 && i < 50)
    begin
      @(negedge clk);
      i++;
    end
    if (i == 50)
    begin
      n_fail++;
      complete_run;
    end
  endtask
  task automatic t_reset;
    apb(0, serial_control_off, 0);
    chk("control", 32'h40, r);
    apb(0, 12'h100, 0);
    chk("slverr", 1, err);
    peer.send(8'h5a, 1, 1);
    apb(0, fifo_status_off, 0);
    chk("fifo status", 32'h5, r);
    apb(0, serial_data_off, 0);
    chk("empty read", 0, r[7:0]);
  endtask
  task automatic t_filter;
    logic b;
    for (int m = 0; m < 2; m++)
    begin
      b = m[0];
      apb(1, serial_control_off, {24'h0, b, 7'h72});
      apb(1, irq_enable_off, 32'h2);
      peer.send(8'h11, !b, b);
      peer.send(8'h22, b, !b);
      repeat (2) @(negedge clk);
      chk("irq rx", 1, irq);
      apb(0, serial_control_off, 0);
      chk("rx_avail", 1, r[rx_avail_pos]);
      apb(0, serial_data_off, 0);
      chk("rx byte", 8'h22, r[7:0]);
      apb(0, serial_control_off, 0);
      chk("rx_avail", 0, r[rx_avail_pos]);
      chk("ninth_rx", 1, r[ninth_rx_pos]);
      apb(0, serial_data_off, 0);
      chk("repeat byte", 8'h22, r[7:0]);
      apb(1, irq_clear_off, 32'h2);
      repeat (2) @(negedge clk);
      chk("irq cleared", 0, irq);
    end
    // filter off: a frame is taken whatever its stop and ninth bits
    apb(1, serial_control_off, 32'h50);
    peer.send(8'h33, 0, 0);
    apb(0, serial_data_off, 0);
    chk("unfiltered byte", 8'h33, r[7:0]);
    apb(0, serial_control_off, 0);
    chk("ninth_rx stop", 0, r[ninth_rx_pos]);
  endtask
  task automatic t_disabled_read;
    peer.send(8'ha1, 1, 1);
    peer.send(8'ha2, 1, 1);
    apb(1, serial_control_off, 32'he2);
    peer.send(8'ha3, 1, 1);
    apb(0, serial_data_off, 0);
    chk("held byte", 8'ha1, r[7:0]);
    apb(0, serial_data_off, 0);
    chk("held byte", 8'ha2, r[7:0]);
    apb(0, fifo_status_off, 0);
    chk("fifo status", 32'h5, r);
  endtask
  // 9-bit then 8-bit frame, ninth tx bit set both times
  task automatic t_tx;
    apb(1, irq_enable_off, 32'h1);
    apb(1, serial_control_off, 32'hca);
    apb(1, serial_data_off, 32'h3c);
    wait_stop;
    chk("tx frame", 9'h13c, last_tx);
    chk("9bit mode", 1, tx_frame_9bit);
    repeat (3) @(negedge clk);
    chk("irq tx", 1, irq);
    apb(0, serial_control_off, 0);
    chk("tx_done", 1, r[tx_done_pos]);
    apb(1, serial_control_off, 32'h48);
    apb(1, irq_clear_off, 32'h1);
    apb(0, serial_control_off, 0);
    chk("tx_done", 0, r[tx_done_pos]);
    chk("irq tx off", 0, irq);
    apb(1, serial_data_off, 32'hc3);
    wait_stop;
    chk("tx frame", 9'h0c3, last_tx);
    chk("9bit mode", 0, tx_frame_9bit);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_filter;
    t_disabled_read;
    t_tx;
    complete_run;
  end
endmodule
